// ---- sim/dci_host_model.sv ----
// Purpose: debug host receive side, collects reply bytes
// Assumes: a byte moves on an edge with valid and ready both high
// Notes: slow_i makes the host stall at random
`timescale 1ns/1ps
module dci_host_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic slow_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o
);
  logic [7:0] q[$];
  initial tx_ready_o = 1'b0;
  always @(posedge clk_i) begin
    if (rst_n_i && tx_valid_i && tx_ready_o) begin
      q.push_back(tx_data_i); // Bench reads replies only once queued
    end
    tx_ready_o <= rst_n_i && (!slow_i || $urandom_range(0, 1) == 0);
  end
endmodule

// ---- sim/tb_debug_command_interpreter.sv ----
// Purpose: self-checking bench of the debug command interpreter
// Assumes: small program memory so the CRC pass stays short
// Notes: memory and CPU sides are modelled inline
`timescale 1ns/1ps
`include "dci_defines.svh"
module tb_debug_command_interpreter;
  import dci_pkg::*;
  localparam int PB = 16;
  logic clk, rst_n, rx_v, tx_v, tx_rdy, prot, unl, halted, brk, rdone, pc_wr, halt_o, slow;
  logic step, stuff, xb, mreq, mwe, mack, brken, crst;
  logic [7:0] rx_d, tx_d, insn, mwd, mrd, wd_last;
  logic [15:0] pc, pcw, maddr, wa_last;
  logic [1:0] msp;
  logic [2:0] xlen;
  int fail_count, tests_run, n_step, n_stuff, n_xb, n_pcw, n_wr, cyc;

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  dci_top #(.PROG_BYTES(PB)) dut_u (.CLK_SYS_I(clk), .RESET_N_I(rst_n),
    .RX_DATA_I(rx_d), .RX_VALID_I(rx_v), .TX_DATA_O(tx_d), .TX_VALID_O(tx_v),
    .TX_READY_I(tx_rdy), .READ_PROTECT_I(prot), .FLASH_UNLOCKED_I(unl),
    .CPU_HALTED_I(halted), .BRK_I(brk), .RST_DONE_I(rdone), .PC_I(pc),
    .PC_WR_O(pc_wr), .PC_WDATA_O(pcw), .CPU_HALT_O(halt_o), .BRK_EN_O(brken),
    .CORE_RESET_O(crst), .STEP_O(step), .STUFF_O(stuff), .EXEC_BYTE_O(xb),
    .INSN_BYTE_O(insn), .EXEC_LEN_I(xlen), .MEM_REQ_O(mreq), .MEM_WE_O(mwe),
    .MEM_SPACE_O(msp), .MEM_ADDR_O(maddr), .MEM_WDATA_O(mwd), .MEM_ACK_I(mack),
    .MEM_RDATA_I(mrd));
  dci_host_model host_u (.clk_i(clk), .rst_n_i(rst_n), .slow_i(slow), .tx_data_i(tx_d),
    .tx_valid_i(tx_v), .tx_ready_o(tx_rdy));

  function automatic logic [7:0] mdat(logic [1:0] s, logic [15:0] a);
    return a[7:0] ^ {6'h00, s} ^ 8'h5a;
  endfunction

  function automatic logic [15:0] crc_exp();
    logic [15:0] c;
    logic [7:0] d;
    c = `DCI_CRC_INIT;
    for (int a = 0; a < PB; a++) begin
      d = mdat(2'h1, 16'(a));
      for (int k = 7; k >= 0; k--) begin
        c = {c[14:0], 1'b0} ^ ((c[15] ^ d[k]) ? `DCI_CRC_POLY : 16'h0000);
      end
    end
    return c;
  endfunction

  // Memory answers one cycle after a request; data is a function of space and address
  always @(posedge clk) begin
    cyc++;
    mack <= mreq && !mack;
    mrd <= mdat(msp, maddr);
    n_wr += int'(mreq && mack && mwe);
    if (mreq && mack && mwe) {wa_last, wd_last} <= {maddr, mwd};
    n_step += int'(step);
    n_stuff += int'(stuff);
    n_xb += int'(xb);
    n_pcw += int'(pc_wr);
  end

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(logic [15:0] got, logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(logic [15:0] got, int lo, int hi);
    tests_run++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask

  // Gap after each byte lets a memory write finish before the next byte
  task automatic send(logic [7:0] b);
    @(posedge clk);
    rx_d <= b;
    rx_v <= 1'b1;
    @(posedge clk);
    rx_v <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  task automatic get(int n, output logic [15:0] v);
    for (int k = 0; k < 4000 && host_u.q.size() < n; k++) @(posedge clk);
    if (host_u.q.size() < n) begin
      fail_count++;
      test_done();
    end
    v = 16'h0000;
    repeat (n) v = {v[7:0], host_u.q.pop_front()};
  endtask

  task automatic hdr(logic [7:0] c, logic [15:0] a, int n);
    logic rf;
    rf = (c == `DCI_C_WREG || c == `DCI_C_RREG);
    send(c);
    send(rf ? {4'h0, a[11:8]} : a[15:8]);
    send(a[7:0]);
    if (!rf) send(8'h00);
    send(n[7:0]);
  endtask

  task automatic mem_rd(logic [7:0] c, logic [1:0] s, logic [15:0] a, int n, bit ff);
    logic [15:0] v;
    hdr(c, a, n);
    for (int i = 0; i < n; i++) begin
      get(1, v);
      chk(v, ff ? 16'h00ff : {8'h00, mdat(s, a + 16'(i))});
    end
  endtask

  task automatic mem_wr(logic [7:0] c, logic [15:0] a, int n, int exp);
    int b;
    logic [7:0] x;
    b = n_wr;
    hdr(c, a, n);
    repeat (n) begin
      x = 8'($urandom);
      send(x);
    end
    chk(16'(n_wr - b), 16'(exp));
    if (exp > 0) begin
      chk({8'h00, wd_last}, {8'h00, x});
      chk(wa_last, a + 16'(n - 1));
    end
  endtask

  task automatic pulses(logic [7:0] c, logic [7:0] op, int exp);
    int b;
    b = n_step + n_stuff + n_xb;
    send(c);
    if (c != `DCI_C_STEP) send(op);
    if (c == `DCI_C_EXEC) for (int i = 1; i < exp; i++) send(op ^ 8'h3c);
    chk(16'(n_step + n_stuff + n_xb - b), 16'(exp));
  endtask

  initial begin
    logic [15:0] v, w;
    logic [7:0] r;
    int t0;
    {rx_v, prot, unl, brk, rdone, slow} = '0;
    {rx_d, pc, cyc, mack, mrd} = '0;
    {fail_count, tests_run, n_step, n_stuff, n_xb, n_pcw, n_wr} = '0;
    halted = 1'b1;
    xlen = 3'h2;
    rst_n = 1'b0;
    r = 8'($urandom(58));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    send(`DCI_C_REV);
    get(2, v);
    chk(v, {`DCI_REV_MAJOR, `DCI_REV_MINOR});
    send(`DCI_C_STAT);
    get(1, v);
    chk(v, 16'h0060);
    foreach (r[i]) send(i[0] ? 8'h01 : 8'h13 + 8'($urandom_range(0, 235)));
    repeat (20) @(posedge clk);
    chk(16'(host_u.q.size()), 16'h0000);
    $display("Test status, revision and reserved codes done");
    r = 8'($urandom) & 8'h7f;
    send(`DCI_C_WCTL);
    send(r);
    send(`DCI_C_RCTL);
    get(1, v);
    chk(v, {8'h00, r & `DCI_CTL_WMASK});
    chk(16'({brken, crst}), 16'({r[6], r[0]}));
    brk <= 1'b1;
    rdone <= 1'b1;
    @(posedge clk);
    {brk, rdone} <= 2'b00;
    send(`DCI_C_RCTL);
    get(1, v);
    chk(v, {8'h00, r & 8'he0 | {r[6], 7'h00}});
    send(`DCI_C_WCTL);
    send(8'h80);
    send(`DCI_C_WCTL);
    send(8'h00);
    chk(16'(halt_o), 16'h0000);
    t0 = cyc;
    repeat (100) @(posedge clk);
    send(`DCI_C_WCTL);
    send(8'h80);
    t0 = cyc - t0;
    chk(16'(halt_o), 16'h0001);
    send(`DCI_C_RTC);
    get(2, v);
    chk_rng(v, t0 - 3, t0 + 3);
    send(`DCI_C_RTC);
    get(2, w);
    chk(w, v);
    $display("Test control and runtime counter done");
    pc <= 16'($urandom);
    w = 16'($urandom);
    send(`DCI_C_WPC);
    send(w[15:8]);
    send(w[7:0]);
    chk(pcw, w);
    chk(16'(n_pcw), 16'h0001);
    send(`DCI_C_RPC);
    get(2, v);
    chk(v, pc);
    slow <= 1'b1;
    mem_rd(`DCI_C_RREG, 2'h0, 16'($urandom) & 16'h0ff0, 3, 0);
    mem_rd(`DCI_C_RPM, 2'h1, 16'($urandom), 2, 0);
    mem_rd(`DCI_C_RDM, 2'h2, 16'hfffe, 2, 0);
    send(`DCI_C_CRC);
    get(2, v);
    chk(v, crc_exp());
    slow <= 1'b0;
    mem_wr(`DCI_C_WDM, 16'h1234, 2, 2);
    mem_wr(`DCI_C_WREG, 16'h0010, 1, 1);
    mem_wr(`DCI_C_WPM, 16'h0100, 2, 0);
    unl <= 1'b1;
    mem_wr(`DCI_C_WPM, 16'h0100, 2, 2);
    pulses(`DCI_C_STEP, 8'h00, 1);
    pulses(`DCI_C_STUFF, 8'ha5, 1);
    chk({8'h00, insn}, 16'h00a5);
    pulses(`DCI_C_EXEC, 8'h5c, 2);
    xlen <= 3'h3;
    pulses(`DCI_C_EXEC, 8'h5d, 3);
    chk({8'h00, insn}, 16'h0061);
    $display("Test debug mode access done");
    prot <= 1'b1;
    send(`DCI_C_WCTL);
    send(8'h00);
    send(`DCI_C_RCTL);
    get(1, v);
    chk(v, 16'h0080);
    send(`DCI_C_RPC);
    get(2, v);
    chk(v, 16'hffff);
    mem_rd(`DCI_C_RREG, 2'h0, 16'h0020, 2, 1);
    mem_rd(`DCI_C_RPM, 2'h1, 16'h0003, 2, 1);
    mem_rd(`DCI_C_RDM, 2'h2, 16'h0040, 2, 0);
    mem_wr(`DCI_C_WDM, 16'h0040, 1, 0);
    mem_wr(`DCI_C_WPM, 16'h0040, 1, 0);
    mem_wr(`DCI_C_WREG, 16'h0020, 1, 0);
    mem_wr(`DCI_C_WREG, 16'h0ff8, 2, 2);
    pulses(`DCI_C_STEP, 8'h00, 0);
    pulses(`DCI_C_STUFF, 8'h11, 0);
    pulses(`DCI_C_EXEC, 8'h12, 0);
    send(`DCI_C_REV);
    get(2, v);
    chk(v, {`DCI_REV_MAJOR, `DCI_REV_MINOR});
    $display("Test read protection done");
    rst_n <= 1'b0;
    prot <= 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    w = 16'(n_pcw);
    send(`DCI_C_WPC);
    send(8'h12);
    send(8'h34);
    chk(16'(n_pcw), w);
    mem_rd(`DCI_C_RDM, 2'h2, 16'h0040, 2, 1);
    mem_wr(`DCI_C_WREG, 16'h0ff8, 1, 0);
    send(`DCI_C_CRC);
    get(2, v);
    chk(v, 16'hffff);
    repeat (65540) @(posedge clk);
    send(`DCI_C_RTC);
    get(2, v);
    chk(v, 16'hffff);
    $display("Test normal mode done");
    test_done();
  end
endmodule

// ---- src/dci_defines.svh ----
// Purpose: constants of the debug command interpreter
// Assumes: byte stream already framed by the serial bit layer
// Notes: some of these numbers are also written out as literals, e.g. control bit 7 in an assertion
`ifndef DCI_DEFINES_SVH
`define DCI_DEFINES_SVH
`define DCI_C_REV 8'h00
`define DCI_C_STAT 8'h02
`define DCI_C_RTC 8'h03
`define DCI_C_WCTL 8'h04
`define DCI_C_RCTL 8'h05
`define DCI_C_WPC 8'h06
`define DCI_C_RPC 8'h07
`define DCI_C_WREG 8'h08
`define DCI_C_RREG 8'h09
`define DCI_C_WPM 8'h0a
`define DCI_C_RPM 8'h0b
`define DCI_C_WDM 8'h0c
`define DCI_C_RDM 8'h0d
`define DCI_C_CRC 8'h0e
`define DCI_C_STEP 8'h10
`define DCI_C_STUFF 8'h11
`define DCI_C_EXEC 8'h12
`define DCI_REV_MAJOR 8'h01
`define DCI_REV_MINOR 8'h00
`define DCI_CTL_RESET 8'h00
`define DCI_CTL_WMASK 8'he1
`define DCI_CTL_DBG 7
`define DCI_CTL_BRK 6
`define DCI_CTL_RST 0
`define DCI_CRC_POLY 16'h1021
`define DCI_CRC_INIT 16'hffff
`define DCI_FLASH_LO 12'hff8
`define DCI_FLASH_HI 12'hff9
`define DCI_PROG_BYTES 65536
`define DCI_SP_REG 2'h0
`define DCI_SP_PROG 2'h1
`define DCI_SP_DATA 2'h2
`endif

// ---- src/dci_pkg.sv ----
// Purpose: types of the debug command interpreter
// Assumes: nothing
// Notes: one-hot state codes
package dci_pkg;
  typedef enum logic [7:0] {
    DCI_IDLE = 8'h01,
    DCI_HDR = 8'h02,
    DCI_XFER = 8'h04,
    DCI_MEMW = 8'h08,
    DCI_SEND = 8'h10,
    DCI_XLEN = 8'h20
  } dci_state_t;
  typedef struct packed {
    dci_state_t st;
    logic [7:0] cmd;
    logic [7:0] ctl;
    logic [15:0] rtc;
    logic [23:0] hdr;
    logic [2:0] need;
    logic [16:0] cnt;
    logic [15:0] addr;
    logic [1:0] space;
    logic wr;
    logic ok;
    logic [15:0] resp;
    logic [1:0] rlen;
    logic [15:0] crc;
    logic mem_req;
    logic [7:0] wdata;
    logic [15:0] pcw;
    logic pc_wr;
    logic step;
    logic stuff;
    logic xb;
    logic xfirst;
    logic [7:0] xbyte;
  } dci_st_t;
endpackage

// ---- src/dci_top.sv ----
// Purpose: command decoder of the on-chip debugger
// Assumes: RX bytes come from same-clock serial layer, slower than MEM_ACK_I
// Notes: one request at a time on the memory port
`timescale 1ns/1ps
`include "dci_defines.svh"
module dci_top
  import dci_pkg::*;
#(
  parameter int PROG_BYTES = `DCI_PROG_BYTES
) (
  input wire logic CLK_SYS_I,
  input wire logic RESET_N_I,
  input wire logic [7:0] RX_DATA_I,
  input wire logic RX_VALID_I,
  output logic [7:0] TX_DATA_O,
  output logic TX_VALID_O,
  input wire logic TX_READY_I,
  input wire logic READ_PROTECT_I,
  input wire logic FLASH_UNLOCKED_I,
  input wire logic CPU_HALTED_I,
  input wire logic BRK_I,
  input wire logic RST_DONE_I,
  input wire logic [15:0] PC_I,
  output logic PC_WR_O,
  output logic [15:0] PC_WDATA_O,
  output logic CPU_HALT_O,
  output logic BRK_EN_O,
  output logic CORE_RESET_O,
  output logic STEP_O,
  output logic STUFF_O,
  output logic EXEC_BYTE_O,
  output logic [7:0] INSN_BYTE_O,
  input wire logic [2:0] EXEC_LEN_I,
  output logic MEM_REQ_O,
  output logic MEM_WE_O,
  output logic [1:0] MEM_SPACE_O,
  output logic [15:0] MEM_ADDR_O,
  output logic [7:0] MEM_WDATA_O,
  input wire logic MEM_ACK_I,
  input wire logic [7:0] MEM_RDATA_I
);
  dci_st_t q;
  dci_st_t d;

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ `DCI_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  logic dbg;
  logic prot;
  logic okp;
  logic [31:0] hv;
  logic flash_hit;
  logic [16:0] pbytes;

  assign dbg = q.ctl[`DCI_CTL_DBG];
  assign prot = READ_PROTECT_I;
  assign okp = dbg & ~prot;
  assign hv = {q.hdr, RX_DATA_I};
  assign flash_hit = (q.addr[11:0] >= `DCI_FLASH_LO) && (q.addr[11:0] <= `DCI_FLASH_HI);
  assign pbytes = 17'(PROG_BYTES);

  always_comb begin
    d = q;
    d.pc_wr = 1'b0;
    d.step = 1'b0;
    d.stuff = 1'b0;
    d.xb = 1'b0;
    case (q.st)
      DCI_IDLE: begin
        if (RX_VALID_I) begin
          d.cmd = RX_DATA_I;
          d.cnt = 17'h00001;
          d.st = DCI_SEND;
          d.rlen = 2'h2;
          case (RX_DATA_I)
            `DCI_C_REV: d.resp = {`DCI_REV_MAJOR, `DCI_REV_MINOR};
            `DCI_C_STAT: begin
              d.resp = {dbg, CPU_HALTED_I, ~prot, 5'h00, 8'h00};
              d.rlen = 2'h1;
            end
            `DCI_C_RTC: d.resp = q.rtc;
            `DCI_C_RCTL: begin
              d.resp = {q.ctl, 8'h00};
              d.rlen = 2'h1;
            end
            `DCI_C_RPC: d.resp = okp ? PC_I : 16'hffff;
            `DCI_C_WCTL, `DCI_C_STUFF, `DCI_C_EXEC: begin
              d.need = 3'h1;
              d.xfirst = 1'b1;
              d.st = DCI_HDR;
            end
            `DCI_C_WPC: begin
              d.need = 3'h2;
              d.st = DCI_HDR;
            end
            `DCI_C_WREG, `DCI_C_RREG: begin
              d.need = 3'h3;
              d.space = `DCI_SP_REG;
              d.st = DCI_HDR;
            end
            `DCI_C_WPM, `DCI_C_RPM, `DCI_C_WDM, `DCI_C_RDM: begin
              d.need = 3'h4;
              d.space = (RX_DATA_I[3:0] < 4'hc) ? `DCI_SP_PROG : `DCI_SP_DATA;
              d.st = DCI_HDR;
            end
            `DCI_C_CRC: begin
              d.resp = 16'hffff;
              if (dbg) begin
                d.addr = 16'h0000;
                d.cnt = pbytes;
                d.crc = `DCI_CRC_INIT;
                d.space = `DCI_SP_PROG;
                d.wr = 1'b0;
                d.mem_req = 1'b1;
                d.st = DCI_MEMW;
              end
            end
            `DCI_C_STEP: begin
              d.step = okp;
              d.st = DCI_IDLE;
            end
            default: d.st = DCI_IDLE;
          endcase
        end
      end
      DCI_HDR: begin
        if (RX_VALID_I) begin
          d.hdr = hv[23:0];
          d.need = q.need - 3'h1;
          // Every byte after the opcode goes on to the core
          if (q.cmd == `DCI_C_EXEC && !q.xfirst) begin
            d.xbyte = RX_DATA_I;
            d.xb = okp;
          end
          if (q.need == 3'h1) begin
            d.st = DCI_IDLE;
            case (q.cmd)
              `DCI_C_WCTL: begin
                // Protected: debug bit can be set but never cleared
                d.ctl = RX_DATA_I & `DCI_CTL_WMASK;
                d.ctl[`DCI_CTL_DBG] = RX_DATA_I[7] | (prot & dbg);
              end
              `DCI_C_WPC: begin
                d.pcw = hv[15:0];
                d.pc_wr = okp;
              end
              `DCI_C_WREG, `DCI_C_RREG: begin
                d.addr = {4'h0, hv[19:8]};
                d.cnt = (hv[7:0] == 8'h00) ? 17'h00100 : {9'h000, hv[7:0]};
                d.wr = (q.cmd == `DCI_C_WREG);
                d.ok = (q.cmd == `DCI_C_WREG) ? dbg : okp;
                d.st = DCI_XFER;
              end
              `DCI_C_WPM, `DCI_C_RPM, `DCI_C_WDM, `DCI_C_RDM: begin
                d.addr = hv[31:16];
                d.cnt = (hv[15:0] == 16'h0000) ? 17'h10000 : {1'b0, hv[15:0]};
                d.wr = ~q.cmd[0];
                case (q.cmd)
                  `DCI_C_WPM: d.ok = okp & FLASH_UNLOCKED_I;
                  `DCI_C_RPM: d.ok = okp;
                  `DCI_C_WDM: d.ok = okp;
                  default: d.ok = dbg;
                endcase
                d.st = DCI_XFER;
              end
              `DCI_C_STUFF: begin
                d.xbyte = RX_DATA_I;
                d.stuff = okp;
              end
              default: begin
                // Execute: blocked takes exactly one byte
                d.xbyte = RX_DATA_I;
                d.xb = okp;
                if (okp && q.xfirst) begin
                  d.st = DCI_XLEN;
                end
              end
            endcase
          end
        end
      end
      DCI_XLEN: begin
        // Length decoded by the core from the opcode on INSN_BYTE_O
        d.xfirst = 1'b0;
        d.need = EXEC_LEN_I - 3'h1;
        d.st = (EXEC_LEN_I > 3'h1) ? DCI_HDR : DCI_IDLE;
      end
      DCI_XFER: begin
        if (!q.wr) begin
          if (q.ok) begin
            d.mem_req = 1'b1;
            d.st = DCI_MEMW;
          end else begin
            d.resp = 16'hffff;
            d.rlen = 2'h1;
            d.st = DCI_SEND;
          end
        end else if (RX_VALID_I) begin
          d.wdata = RX_DATA_I;
          if (q.ok && (q.space != `DCI_SP_REG || !prot || flash_hit)) begin
            d.mem_req = 1'b1;
            d.st = DCI_MEMW;
          end else begin
            d.addr = q.addr + 16'h0001;
            d.cnt = q.cnt - 17'h00001;
            d.st = (q.cnt == 17'h00001) ? DCI_IDLE : DCI_XFER;
          end
        end
      end
      DCI_MEMW: begin
        if (MEM_ACK_I) begin
          d.mem_req = 1'b0;
          d.addr = q.addr + 16'h0001;
          if (q.cmd == `DCI_C_CRC) begin
            d.crc = crc_byte(q.crc, MEM_RDATA_I);
            d.cnt = q.cnt - 17'h00001;
            if (q.cnt == 17'h00001) begin
              // One reply pass left so SEND ends in idle
              d.cnt = 17'h00001;
              d.resp = d.crc;
              d.rlen = 2'h2;
              d.st = DCI_SEND;
            end else begin
              d.mem_req = 1'b1;
            end
          end else if (!q.wr) begin
            d.resp = {MEM_RDATA_I, 8'h00};
            d.rlen = 2'h1;
            d.st = DCI_SEND;
          end else begin
            d.cnt = q.cnt - 17'h00001;
            d.st = (q.cnt == 17'h00001) ? DCI_IDLE : DCI_XFER;
          end
        end
      end
      DCI_SEND: begin
        if (TX_READY_I) begin
          d.resp = {q.resp[7:0], 8'h00};
          d.rlen = q.rlen - 2'h1;
          if (q.rlen == 2'h1) begin
            d.cnt = q.cnt - 17'h00001;
            d.st = (q.cnt == 17'h00001) ? DCI_IDLE : DCI_XFER;
          end
        end
      end
      default: d.st = DCI_IDLE;
    endcase
    if (BRK_I && q.ctl[`DCI_CTL_BRK]) begin
      d.ctl[`DCI_CTL_DBG] = 1'b1;
    end
    if (RST_DONE_I) begin
      d.ctl[`DCI_CTL_RST] = 1'b0;
    end
    // Counter restarts from zero on leaving debug mode
    if (dbg && !d.ctl[`DCI_CTL_DBG]) begin
      d.rtc = 16'h0000;
    end else if (!dbg && q.rtc != 16'hffff) begin
      d.rtc = q.rtc + 16'h0001;
    end
    // Codes from WREG to EXEC, except 0fh, clear the counter
    if (q.st == DCI_IDLE && RX_VALID_I && RX_DATA_I >= `DCI_C_WREG
        && RX_DATA_I <= `DCI_C_EXEC && RX_DATA_I != 8'h0f) begin
      d.rtc = 16'h0000;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      q <= '0;
      q.st <= DCI_IDLE;
      q.ctl <= `DCI_CTL_RESET;
    end else begin
      q <= d;
    end
  end

  assign TX_VALID_O = (q.st == DCI_SEND);
  assign TX_DATA_O = q.resp[15:8];
  assign PC_WR_O = q.pc_wr;
  assign PC_WDATA_O = q.pcw;
  assign CPU_HALT_O = q.ctl[`DCI_CTL_DBG];
  assign BRK_EN_O = q.ctl[`DCI_CTL_BRK];
  assign CORE_RESET_O = q.ctl[`DCI_CTL_RST];
  assign STEP_O = q.step;
  assign STUFF_O = q.stuff;
  assign EXEC_BYTE_O = q.xb;
  assign INSN_BYTE_O = q.xbyte;
  assign MEM_REQ_O = q.mem_req;
  assign MEM_WE_O = q.wr;
  assign MEM_SPACE_O = q.space;
  assign MEM_ADDR_O = q.addr;
  assign MEM_WDATA_O = q.wdata;

  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RESET_N_I);

  logic rx_cmd;
  assign rx_cmd = (q.st == DCI_IDLE) && RX_VALID_I;

  chk_rev_major: assert property (rx_cmd && RX_DATA_I == `DCI_C_REV |=>
      TX_VALID_O && TX_DATA_O == `DCI_REV_MAJOR) else $error("bad revision byte");
  chk_rtc_sat: assert property (q.rtc == 16'hffff
      && !(rx_cmd && RX_DATA_I >= `DCI_C_WREG) && !(dbg && !d.ctl[7])
      |=> q.rtc == 16'hffff) else $error("counter wrapped");
  chk_rtc_count: assert property (!dbg && $past(!dbg) && q.rtc != 16'hffff && q.rtc != 0
      |-> q.rtc == $past(q.rtc) + 16'h0001 || $past(rx_cmd)) else $error("counter stalled");
  chk_prot_sticky: assert property (prot && dbg && !RST_DONE_I |=> dbg)
      else $error("debug bit cleared under protection");
  chk_pc_gate: assert property (PC_WR_O |-> $past(okp))
      else $error("counter written while blocked");
  chk_rpc_ones: assert property (rx_cmd && RX_DATA_I == `DCI_C_RPC && !okp |=>
      TX_DATA_O == 8'hff ##1 TX_DATA_O == 8'hff || !TX_READY_I) else $error("pc not ones");
  chk_step_gate: assert property (STEP_O |-> $past(okp))
      else $error("step while blocked");
  chk_stuff_gate: assert property (STUFF_O |-> $past(okp))
      else $error("stuff while blocked");
  chk_exec_one: assert property (q.st == DCI_HDR && q.cmd == `DCI_C_EXEC && q.xfirst
      && !okp && RX_VALID_I |=> q.st == DCI_IDLE) else $error("blocked execute took more");
  chk_reserved: assert property (rx_cmd && RX_DATA_I > `DCI_C_EXEC |=>
      q.st == DCI_IDLE && !TX_VALID_O) else $error("reserved code acted");
  chk_halt_out: assert property (BRK_I && BRK_EN_O |=> CPU_HALT_O)
      else $error("breakpoint did not halt");
  chk_mem_gate: assert property (MEM_REQ_O && MEM_WE_O |-> dbg)
      else $error("write outside debug mode");
  chk_crc_ones: assert property (rx_cmd && RX_DATA_I == `DCI_C_CRC && !dbg |=>
      TX_VALID_O && TX_DATA_O == 8'hff) else $error("crc not ones");
  chk_exec_gate: assert property (EXEC_BYTE_O |-> $past(okp))
      else $error("execute byte while blocked");
  chk_ctl_read: assert property (rx_cmd && RX_DATA_I == `DCI_C_RCTL |=>
      TX_VALID_O && TX_DATA_O == $past(q.ctl)) else $error("control read wrong");
  chk_stat_read: assert property (rx_cmd && RX_DATA_I == `DCI_C_STAT |=>
      TX_DATA_O == {$past(dbg), $past(CPU_HALTED_I), $past(!prot), 5'h00})
      else $error("status byte wrong");

  cov_crc: cover property (q.cmd == `DCI_C_CRC && q.st == DCI_SEND);
  cov_rreg: cover property (q.cmd == `DCI_C_RREG && TX_VALID_O && TX_READY_I);
  cov_exec: cover property (q.st == DCI_XLEN);
  cov_flash_wr: cover property (prot && MEM_REQ_O && MEM_WE_O && MEM_SPACE_O == `DCI_SP_REG);
  cov_exec_mid: cover property (EXEC_BYTE_O && q.st == DCI_HDR);
endmodule
